//--- rtl/sbrg_top.sv
// The placing of the registers and the APB interface to the registers were decided locally.
`default_nettype none
`include "sbrg_map.svh"

module sbrg_top
    import sbrg_pkg::*;
#(
    parameter int AW = 12
) (
    input  wire logic          core_clk_i,
    input  wire logic          nrst_i,
    input  wire logic          psel_i,
    input  wire logic          penable_i,
    input  wire logic          pwrite_i,
    input  wire logic [AW-1:0] paddr_i,
    input  wire logic [31:0]   pwdata_i,
    output logic      [31:0]   prdata_o,
    output logic               pready_o,
    output logic               pslverr_o,
    input  wire logic          rx_valid_i,
    input  wire sbrg_rxch_t    rx_char_i,
    output logic               rx_enable_o,
    output logic               baud_tick_o,
    output logic               irq_o
);

    logic       acc;
    logic       wr_en;
    logic       rd_en;
    logic       hit;
    logic [31:0] rdata;
    logic       wr_ctrl;
    logic       wr_div;
    logic       wr_rc;
    logic       rd_buf;
    logic       pready_next;
    logic       pslverr_next;
    logic [31:0] prdata_next;

    assign acc    = psel_i & penable_i & ~pready_o;
    assign wr_en  = psel_i & penable_i & pready_o & pwrite_i;
    assign rd_en  = psel_i & penable_i & pready_o & ~pwrite_i;
    assign wr_ctrl = wr_en && paddr_i == `SBRG_OFF_CTRL;
    assign wr_div = wr_en && paddr_i == `SBRG_OFF_DIV;
    assign wr_rc  = wr_en && paddr_i == `SBRG_OFF_RXSC;
    assign rd_buf = rd_en && paddr_i == `SBRG_OFF_RXBUF;

    sbrg_ctrl_t  ctrl_reg;
    sbrg_ctrl_t  ctrl_next;
    logic [7:0]  div_reg;
    logic [7:0]  div_next;
    logic [7:0]  rc_reg;
    logic [7:0]  rc_next;
    logic [7:0]  buf_reg;
    logic [7:0]  buf_next;
    logic        full_reg;
    logic        full_next;
    logic [2:0]  ist_reg;
    logic [2:0]  ist_next;
    logic [2:0]  ien_reg;
    logic [2:0]  ien_next;
    logic        irq_next;
    logic        rxen_next;

    always_comb begin
        hit   = 1'b1;
        rdata = 32'h0000_0000;
        unique case (paddr_i)
            `SBRG_OFF_CTRL:  rdata[1:0] = ctrl_reg;
            `SBRG_OFF_DIV:   rdata[7:0] = div_reg;
            `SBRG_OFF_RXSC:  rdata[7:0] = rc_reg;
            `SBRG_OFF_RXBUF: rdata[7:0] = buf_reg;
            `SBRG_OFF_ISTAT: rdata[2:0] = ist_reg;
            `SBRG_OFF_ICLR:  rdata = 32'h0000_0000;
            `SBRG_OFF_IEN:   rdata[2:0] = ien_reg;
            default:         hit = 1'b0;
        endcase
        pready_next  = acc;
        pslverr_next = acc & ~hit;
        prdata_next  = prdata_o;
        if (acc) begin
            prdata_next = pwrite_i ? 32'h0000_0000 : rdata;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h0000_0000;
        end else begin
            pready_o  <= pready_next;
            pslverr_o <= pslverr_next;
            prdata_o  <= prdata_next;
        end
    end

    // Baud generator: a prescaler sets the multiplier, the 8-bit timer the divisor.
    logic [6:0] mult;
    logic [6:0] pre_reg;
    logic [6:0] pre_next;
    logic [7:0] tmr_reg;
    logic [7:0] tmr_next;
    logic       tick_next;

    always_comb begin
        if (ctrl_reg.sync) begin
            mult = `SBRG_MUL_SYN;
        end else if (ctrl_reg.hs) begin
            mult = `SBRG_MUL_AHS;
        end else begin
            mult = `SBRG_MUL_ALS;
        end
        pre_next  = pre_reg + 7'h01;
        tmr_next  = tmr_reg;
        tick_next = 1'b0;
        if (pre_reg >= mult - 7'h01) begin
            pre_next = 7'h00;
            // period mult times n plus one
            if (tmr_reg >= div_reg) begin
                tmr_next  = 8'h00;
                tick_next = 1'b1;
            end else begin
                tmr_next = tmr_reg + 8'h01;
            end
        end
        if (wr_div) begin
            pre_next = 7'h00;
            tmr_next = 8'h00;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre_reg     <= 7'h00;
            tmr_reg     <= 8'h00;
            baud_tick_o <= 1'b0;
        end else begin
            pre_reg     <= pre_next;
            tmr_reg     <= tmr_next;
            baud_tick_o <= tick_next;
        end
    end

    // Receive control, buffer, flags and interrupts.
    logic rx_on;
    logic drop;
    logic load;
    logic ovr;

    assign rx_on = rc_reg[`SBRG_RC_PORT_ON] &
                   (rc_reg[`SBRG_RC_CONT_ON] | (ctrl_reg.sync & rc_reg[`SBRG_RC_ONE_SHOT]));
    assign drop  = rc_reg[`SBRG_RC_ADDR_DET] & rc_reg[`SBRG_RC_NINE_ON] &
                   ~ctrl_reg.sync & ~rx_char_i.data[8];
    assign load  = rx_valid_i & rx_on & ~drop & ~full_reg & ~rc_reg[`SBRG_RC_OVER];
    assign ovr   = rx_valid_i & rx_on & ~drop & full_reg;

    always_comb begin
        ctrl_next = ctrl_reg;
        div_next  = div_reg;
        rc_next   = rc_reg;
        buf_next  = buf_reg;
        full_next = full_reg;
        ien_next  = ien_reg;
        ist_next  = ist_reg;
        if (wr_ctrl) begin
            ctrl_next = pwdata_i[1:0];
        end
        if (wr_div) begin
            div_next = pwdata_i[7:0];
        end
        if (wr_en && paddr_i == `SBRG_OFF_IEN) begin
            ien_next = pwdata_i[2:0];
        end
        if (wr_rc) begin
            rc_next = (rc_reg & ~`SBRG_RC_WMASK) | (pwdata_i[7:0] & `SBRG_RC_WMASK);
            if (!pwdata_i[`SBRG_RC_CONT_ON]) begin
                rc_next[`SBRG_RC_OVER] = 1'b0;
            end
        end
        if (rd_buf) begin
            full_next = 1'b0;
        end
        if (wr_en && paddr_i == `SBRG_OFF_ICLR) begin
            ist_next = ist_reg & ~pwdata_i[2:0];
        end
        if (load) begin
            buf_next  = rx_char_i.data[7:0];
            full_next = 1'b1;
            rc_next[`SBRG_RC_NINTH] = rx_char_i.data[8];
            rc_next[`SBRG_RC_FRAME] = rx_char_i.frame_err;
            ist_next[`SBRG_IRQ_RXCH] = 1'b1;
            if (rx_char_i.frame_err) begin
                ist_next[`SBRG_IRQ_FRM] = 1'b1;
            end
            if (ctrl_reg.sync) begin
                rc_next[`SBRG_RC_ONE_SHOT] = 1'b0;
            end
        end
        if (ovr) begin
            rc_next[`SBRG_RC_OVER]  = 1'b1;
            ist_next[`SBRG_IRQ_OVR] = 1'b1;
        end
        irq_next  = |(ist_next & ien_next);
        rxen_next = rc_next[`SBRG_RC_PORT_ON] &
                    (rc_next[`SBRG_RC_CONT_ON] | (ctrl_next.sync & rc_next[`SBRG_RC_ONE_SHOT]));
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_reg    <= `SBRG_RST_CTRL;
            div_reg     <= `SBRG_RST_DIV;
            rc_reg      <= `SBRG_RST_RXSC;
            buf_reg     <= 8'h00;
            full_reg    <= 1'b0;
            ist_reg     <= `SBRG_RST_IRQ;
            ien_reg     <= `SBRG_RST_IRQ;
            irq_o       <= 1'b0;
            rx_enable_o <= 1'b0;
        end else begin
            ctrl_reg    <= ctrl_next;
            div_reg     <= div_next;
            rc_reg      <= rc_next;
            buf_reg     <= buf_next;
            full_reg    <= full_next;
            ist_reg     <= ist_next;
            ien_reg     <= ien_next;
            irq_o       <= irq_next;
            rx_enable_o <= rxen_next;
        end
    end

    // Cycles since the last tick or divisor write; clean flag cleared whenever the rate setting may change.
    logic [15:0] gap_reg;
    logic        clean_reg;

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gap_reg   <= 16'h0000;
            clean_reg <= 1'b0;
        end else begin
            gap_reg   <= (baud_tick_o | wr_div) ? 16'h0001 : gap_reg + 16'h0001;
            clean_reg <= wr_div | wr_ctrl ? 1'b0 : (baud_tick_o ? 1'b1 : clean_reg);
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    tick_period_a: assert property (
        baud_tick_o && clean_reg && !wr_ctrl |-> gap_reg == 16'(mult) * (16'(div_reg) + 16'h0001))
        else $error("baud tick period wrong");

    div_restart_a: assert property (
        wr_div |=> tmr_reg == 8'h00 && pre_reg == 7'h00)
        else $error("divisor write did not clear timer");

    sync_mult_a: assert property (
        ctrl_reg.sync |-> mult == 7'h04)
        else $error("sync mode multiplier wrong");

    async_mult_a: assert property (
        !ctrl_reg.sync |-> mult == (ctrl_reg.hs ? 7'h10 : 7'h40))
        else $error("async multiplier wrong");

    timer_bound_a: assert property (
        tmr_reg <= div_reg && (pre_reg < mult || $past(wr_ctrl)))
        else $error("timer beyond divisor");

    shared_tick_a: assert property (
        baud_tick_o |-> $past(tmr_reg) == $past(div_reg))
        else $error("tick without timer reload");

    ovr_hold_a: assert property (
        rc_reg[`SBRG_RC_OVER] && !(wr_rc && !pwdata_i[`SBRG_RC_CONT_ON]) |=> rc_reg[`SBRG_RC_OVER])
        else $error("overrun flag dropped");

    ovr_clear_a: assert property (
        wr_rc && !pwdata_i[`SBRG_RC_CONT_ON] && !ovr |=> !rc_reg[`SBRG_RC_OVER])
        else $error("overrun not cleared");

    pass_all_a: assert property (
        rx_valid_i && rx_on && !rc_reg[`SBRG_RC_ADDR_DET] && !full_reg && !rc_reg[`SBRG_RC_OVER]
        |=> full_reg && ist_reg[`SBRG_IRQ_RXCH])
        else $error("character not passed");

    frame_load_a: assert property (
        load |=> rc_reg[`SBRG_RC_FRAME] == $past(rx_char_i.frame_err))
        else $error("framing flag not refreshed");

    irq_level_a: assert property (
        irq_o == |(ist_reg & ien_reg))
        else $error("interrupt level wrong");

    tick_c: cover property (baud_tick_o ##[1:300] baud_tick_o);
    ovr_c: cover property (ovr);
    drop_c: cover property (rx_valid_i && rx_on && drop);
    irq_c: cover property (irq_o);

endmodule : sbrg_top
`default_nettype wire

//--- rtl/sbrg_map.svh
`ifndef SBRG_MAP_SVH
`define SBRG_MAP_SVH
`define SBRG_OFF_CTRL    12'h000
`define SBRG_OFF_DIV     12'h004
`define SBRG_OFF_RXSC    12'h008
`define SBRG_OFF_RXBUF   12'h00C
`define SBRG_OFF_ISTAT   12'h010
`define SBRG_OFF_ICLR    12'h014
`define SBRG_OFF_IEN     12'h018
`define SBRG_CTL_SYNC    0
`define SBRG_CTL_HS      1
`define SBRG_RC_PORT_ON  7
`define SBRG_RC_NINE_ON  6
`define SBRG_RC_ONE_SHOT 5
`define SBRG_RC_CONT_ON  4
`define SBRG_RC_ADDR_DET 3
`define SBRG_RC_FRAME    2
`define SBRG_RC_OVER     1
`define SBRG_RC_NINTH    0
`define SBRG_RC_WMASK    8'hF8
`define SBRG_IRQ_RXCH    0
`define SBRG_IRQ_OVR     1
`define SBRG_IRQ_FRM     2
`define SBRG_RST_CTRL    2'h0
`define SBRG_RST_DIV     8'h00
`define SBRG_RST_RXSC    8'h00
`define SBRG_RST_IRQ     3'h0
`define SBRG_MUL_ALS     7'h40
`define SBRG_MUL_AHS     7'h10
`define SBRG_MUL_SYN     7'h04
`endif

//--- rtl/sbrg_pkg.sv
`default_nettype none
package sbrg_pkg;
    typedef struct packed {
        logic [8:0] data;
        logic       frame_err;
    } sbrg_rxch_t;

    typedef struct packed {
        logic        hs;
        logic        sync;
    } sbrg_ctrl_t;
endpackage : sbrg_pkg
`default_nettype wire

//--- tb/sbrg_rx_partner.sv
`default_nettype none
module sbrg_rx_partner
    import sbrg_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       baud_tick_i,
    input  wire logic       send_i,
    input  wire logic [1:0] gap_i,
    input  wire sbrg_rxch_t char_i,
    output logic            busy_o,
    output logic            rx_valid_o,
    output sbrg_rxch_t      rx_char_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] gap_reg;
    logic       pend_reg;
    sbrg_rxch_t hold_reg;

    assign busy_o = pend_reg | rx_valid_o;

    // A slow sender waits gap_i baud ticks before presenting the character; between characters the lines toggle so stale data never matches.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gap_reg    <= 2'h0;
            pend_reg   <= 1'b0;
            hold_reg   <= '0;
            rx_valid_o <= 1'b0;
            rx_char_o  <= '0;
        end else begin
            rx_valid_o <= 1'b0;
            rx_char_o  <= ~rx_char_o;
            if (send_i) begin
                pend_reg <= 1'b1;
                gap_reg  <= gap_i;
                hold_reg <= char_i;
            end else if (pend_reg && gap_reg != 2'h0) begin
                if (baud_tick_i) gap_reg <= gap_reg - 2'h1;
            end else if (pend_reg) begin
                pend_reg   <= 1'b0;
                rx_valid_o <= 1'b1;
                rx_char_o  <= hold_reg;
            end
        end
    end
endmodule : sbrg_rx_partner
`default_nettype wire

//--- tb/sbrg_top_tb.sv
`default_nettype none
`include "sbrg_map.svh"
module sbrg_top_tb
    import sbrg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] RSC_ADDR = 12'h008;
    localparam logic [11:0] BAD_ADDR = 12'h01C;
    logic        clk;
    logic        nrst;
    logic        psel;
    logic        pen;
    logic        pwr;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rxv;
    sbrg_rxch_t  rxc;
    logic        tick;
    logic        irq;
    logic        send;
    logic [1:0]  gap;
    sbrg_rxch_t  chr;
    logic        busy;
    logic        rxen;
    logic        done = 1'b0;
    int          error_cnt;
    int          check_count;
    logic [31:0] q;
    logic        e;
    logic [7:0]  dv;
    logic [8:0]  d9;
    logic        f;
    int          n;
    int          p;

    sbrg_top i_sbrg_top (.core_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .rx_valid_i(rxv), .rx_char_i(rxc), .rx_enable_o(rxen), .baud_tick_o(tick), .irq_o(irq));
    sbrg_rx_partner i_sbrg_rx_partner (.clk_i(clk), .nrst_i(nrst), .baud_tick_i(tick), .send_i(send),
        .gap_i(gap), .char_i(chr), .busy_o(busy), .rx_valid_o(rxv), .rx_char_o(rxc));

    always #5 clk = ~clk;

    function automatic int period(input logic [1:0] m, input logic [7:0] v);
        return (m[`SBRG_CTL_SYNC] ? 4 : (m[`SBRG_CTL_HS] ? 16 : 64)) * (int'(v) + 1);
    endfunction : period

    function automatic logic [31:0] rsc(input logic [7:0] c, input logic fe, input logic ov, input logic b);
        return {24'h0, c[7:3], fe, ov, b};
    endfunction : rsc

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic timeout();
        error_cnt++;
        $display("ERROR %0t: wait limit reached", $time);
        done = 1'b1;
        disable main_seq;
    endtask : timeout

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) timeout();
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd

    task automatic wtick();
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (tick !== 1'b1 && n < 20000);
        if (n >= 20000) timeout();
    endtask : wtick

    task automatic rx(input logic [8:0] d, input logic fe);
        int k;
        k = 0;
        @(posedge clk);
        send     <= 1'b1;
        gap      <= 2'($urandom % 3);
        chr.data <= d;
        chr.frame_err <= fe;
        @(posedge clk);
        send <= 1'b0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (busy !== 1'b0 && k < 200);
        if (k >= 200) timeout();
        @(posedge clk);
        #1;
    endtask : rx

    task automatic finish_test();
        if (error_cnt == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    initial begin
        wait (done === 1'b1);
        finish_test();
    end

    initial begin : main_seq
        error_cnt   = 0;
        check_count = 0;
        clk    = 1'b0;
        nrst   = 1'b0;
        psel   = 1'b0;
        pen    = 1'b0;
        pwr    = 1'b0;
        paddr  = 12'h000;
        pwdata = 32'h0;
        send   = 1'b0;
        gap    = 2'h0;
        chr    = '0;
        n = $urandom(32'h79BE1568);
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(12'(a * 4), 32'h0);
            chk({31'h0, e}, {31'h0, 12'(a * 4) == BAD_ADDR});
        end
        apb(1'b1, BAD_ADDR, 32'hFF);
        chk({31'h0, e}, 32'h1);
        // Divisor 255 in the last two passes exercises the full width of the timer.
        for (int i = 0; i < 6; i++) begin
            dv = (i >= 4) ? 8'hFF : 8'($urandom % 4);
            apb(1'b1, `SBRG_OFF_CTRL, 32'(i % 4));
            apb(1'b1, `SBRG_OFF_DIV, {24'h0, dv});
            p = period(2'(i % 4), dv);
            wtick();
            chk(32'(n >= p && n <= p + 1), 32'h1);
            wtick();
            chk(32'(n), 32'(p));
        end
        apb(1'b1, `SBRG_OFF_CTRL, 32'h2);
        apb(1'b1, `SBRG_OFF_DIV, 32'h0);
        apb(1'b1, RSC_ADDR, 32'h90);
        #1;
        chk({31'h0, rxen}, 32'h1);
        apb(1'b1, `SBRG_OFF_IEN, 32'h7);
        for (int i = 0; i < 6; i++) begin
            d9 = 9'($urandom);
            f  = 1'($urandom);
            rx(d9, f);
            chk({31'h0, irq}, 32'h1);
            rd(`SBRG_OFF_ISTAT, {29'h0, f, 2'h1});
            rd(RSC_ADDR, rsc(8'h90, f, 1'b0, d9[8]));
            rd(`SBRG_OFF_RXBUF, {24'h0, d9[7:0]});
            apb(1'b1, `SBRG_OFF_ICLR, 32'h7);
        end
        rx(9'h0A5, 1'b0);
        rx(9'h15A, 1'b0);
        rd(RSC_ADDR, rsc(8'h90, 1'b0, 1'b1, 1'b0));
        rd(`SBRG_OFF_ISTAT, 32'h3);
        apb(1'b1, `SBRG_OFF_IEN, 32'h0);
        repeat (2) @(posedge clk);
        #1;
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, `SBRG_OFF_IEN, 32'h7);
        rd(`SBRG_OFF_RXBUF, 32'hA5);
        apb(1'b1, `SBRG_OFF_ICLR, 32'h7);
        rx(9'h033, 1'b1);
        rd(`SBRG_OFF_ISTAT, 32'h0);
        apb(1'b1, RSC_ADDR, 32'h80);
        #1;
        chk({31'h0, rxen}, 32'h0);
        rd(RSC_ADDR, 32'h80);
        apb(1'b1, RSC_ADDR, 32'h97);
        rd(RSC_ADDR, 32'h90);
        rx(9'h1C3, 1'b1);
        rd(`SBRG_OFF_ISTAT, 32'h5);
        rd(RSC_ADDR, 32'h95);
        rd(`SBRG_OFF_RXBUF, 32'hC3);
        rx(9'h03C, 1'b0);
        rd(RSC_ADDR, 32'h90);
        rd(`SBRG_OFF_RXBUF, 32'h3C);
        apb(1'b1, `SBRG_OFF_ICLR, 32'h7);
        apb(1'b1, RSC_ADDR, 32'hD8);
        rx(9'h055, 1'b0);
        rd(`SBRG_OFF_ISTAT, 32'h0);
        rx(9'h1AA, 1'b0);
        rd(`SBRG_OFF_RXBUF, 32'hAA);
        apb(1'b1, RSC_ADDR, 32'hD0);
        rx(9'h066, 1'b0);
        rd(`SBRG_OFF_RXBUF, 32'h66);
        // Synchronous single receive: one character loads, then the receiver switches itself off.
        apb(1'b1, `SBRG_OFF_ICLR, 32'h7);
        apb(1'b1, `SBRG_OFF_CTRL, 32'h1);
        apb(1'b1, RSC_ADDR, 32'hA0);
        #1;
        chk({31'h0, rxen}, 32'h1);
        rx(9'h011, 1'b0);
        chk({31'h0, rxen}, 32'h0);
        rd(RSC_ADDR, 32'h80);
        rd(`SBRG_OFF_RXBUF, 32'h11);
        apb(1'b1, `SBRG_OFF_ICLR, 32'h7);
        rx(9'h022, 1'b0);
        rd(`SBRG_OFF_ISTAT, 32'h0);
        done = 1'b1;
    end
endmodule : sbrg_top_tb
`default_nettype wire
